// ===== rtl/ntarb_pkg.sv
// Shared constants and carrier types of the intelligent NT D-channel arbiter.
// Assumes one frame-bus frame is handed over as one word per clk_sys beat.
package ntarb_pkg;

  // --------------------------------------------------------------------------
  // Mode selection
  // --------------------------------------------------------------------------
  localparam logic [1:0] MODE_INT_NT   = 2'h3;  // op-select bits two and one
  localparam logic [2:0] DIM_SG_EVAL   = 3'h1;  // arbitration field value
  localparam int         TE_SLOTS      = 12;    // timeslots of the TE frame

  // --------------------------------------------------------------------------
  // Priority classes and thresholds
  // --------------------------------------------------------------------------
  localparam logic [3:0] PRIO_LOW_CNT  = 4'h8;
  localparam logic [3:0] PRIO_HIGH_CNT = 4'hA;
  localparam logic [3:0] LOWER_LEVEL   = 4'h1;  // added after a success
  localparam int         CNT_W         = 4;

  // --------------------------------------------------------------------------
  // Channel 2 last octet layout
  // --------------------------------------------------------------------------
  localparam int         BAC_POS       = 5;     // on upstream data line
  localparam int         SG_POS        = 5;     // on downstream data line
  localparam logic [7:0] OCT_IDLE      = 8'hFF;
  localparam logic [2:0] SG_CHANNEL    = 3'h2;
  localparam logic [1:0] D_IDLE        = 2'h3;

  typedef enum logic [1:0] {
    NTARB_READY = 2'b00,
    NTARB_GRANT = 2'b01,
    NTARB_BLOCK = 2'b10,
    NTARB_OFF   = 2'b11
  } ntarb_state_t;

  // One frame seen by the arbiter; bit 1 of a D pair is the earlier bit
  typedef struct packed {
    logic [1:0] up_d;       // D bits on upstream data line (wired bus)
    logic [7:0] up_ch2_oct; // last octet of channel 2 on upstream line
    logic [1:0] s_d;        // D bits received from the S bus
    logic       s_active;   // a terminal is active in the D-channel
    logic       line_permit;// permit bit from the exchange
    logic       tx_abort;   // abort seen in the local transmission
  } ntarb_frame_in_t;

  // One frame produced by the arbiter
  typedef struct packed {
    logic [1:0] up_d;       // D bits driven to upstream channel 0
    logic [1:0] echo;       // echo bits sent on the S bus
    logic [7:0] dn_ch2_oct; // last octet of channel 2 on downstream line
    logic [2:0] sg_chan;    // channel that carries the stop/go bit
  } ntarb_frame_out_t;

  typedef struct packed {
    logic [2:0] mode;       // op_select_bit_two, _one, state_machine_select
    logic [2:0] dim;        // dchan_arbitration_field
    logic       dchan_priority_select;      // dchan_priority_select
    logic       te_frame;   // TE frame structure selected
    logic       arb_bus_en; // controller arbitration bus enabled
  } ntarb_cfg_t;

endpackage

// ===== rtl/ntarb_ones_cnt.sv
// Consecutive-ones counter over D bit pairs, saturating.
// Assumes bit 1 of each pair precedes bit 0 on the line.
`timescale 1ns/10ps
module ntarb_ones_cnt #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // Bit pairs
  input  wire logic         bit_valid,
  input  wire logic [1:0]   bits,
  // Count
  output logic      [W-1:0] count
);
  import ntarb_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } ntarb_cnt_st_t;

  ntarb_cnt_st_t st;
  ntarb_cnt_st_t next_st;
  localparam logic [W-1:0] MAXV = '1;

  initial
  begin
    if (W < 4) $error("ntarb_ones_cnt: W too small for eleven");
  end

  always_comb
  begin
    next_st = st;
    if (bit_valid)
    begin
      if (!bits[0])
        next_st.cnt = '0;                                          // RULE21
      else if (!bits[1])
        next_st.cnt = W'(1);                                       // RULE21
      else if (st.cnt >= MAXV - W'(1))
        next_st.cnt = MAXV;
      else
        next_st.cnt = st.cnt + W'(2);                              // RULE4
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign count = st.cnt;

  a_zero_restart: assert property (@(posedge clk_sys) disable iff (reset)
    bit_valid && !bits[0] |=> count == '0)  // RULE21
    else $error("ones count not cleared by zero bit");

endmodule // ntarb_ones_cnt

// ===== rtl/ntarb_skid_buf.sv
// Two-entry buffer with valid/ready on both sides; output from registers.
// Assumes the drain side may hold ready low for any time.
`timescale 1ns/10ps
module ntarb_skid_buf #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  import ntarb_pkg::*;

  typedef struct packed {
    logic             ov;
    logic             sv;
    logic [WIDTH-1:0] od;
    logic [WIDTH-1:0] sd;
  } ntarb_buf_st_t;

  ntarb_buf_st_t st;
  ntarb_buf_st_t next_st;

  initial
  begin
    if (WIDTH < 1) $error("ntarb_skid_buf: WIDTH must be positive");
  end

  always_comb
  begin
    next_st = st;
    if (out_ready || !st.ov)
    begin
      // A full skid slot refuses the offered word, so only the slot moves
      next_st.ov = st.sv || in_valid;
      next_st.od = st.sv ? st.sd : in_data;
      next_st.sv = 1'b0;
    end
    else if (in_valid && !st.sv)
    begin
      next_st.sv = 1'b1;
      next_st.sd = in_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign in_ready  = !st.sv;
  assign out_valid = st.ov;
  assign out_data  = st.od;

endmodule // ntarb_skid_buf

// ===== rtl/ntarb_arbiter.sv
// Intelligent NT upstream D-channel arbiter between frame-bus HDLC
// controllers and S-bus terminals. Assumes one frame word per beat on a
// valid/ready stream, clocked by clk_sys at 200 MHz.
//
// Summary of operation
// RULE1 - Intelligent NT when op-select bits two and one are 1; bit zero picks machine.
// RULE2 - Stop/go is evaluated only when the arbitration field equals 001.
// RULE3 - Arbitration offered only in TE frame with arbitration bus enabled.
// RULE4 - Count ones upstream; on threshold with bus-accessed 0, grant at once.
// RULE5 - Priority class 8 or 10 chosen by the priority select bit.
// RULE6 - Threshold is class after abort, class plus one after success.
// RULE7 - Permit bit 0 stops all sources; stop/go request not evaluated.
// RULE8 - Ready state: bus-accessed seen 1, stop/go driven 1.
// RULE9 - Controller checks bus free, sends address, then drives bus-accessed 0.
// RULE10 - Stop/go falls to 0 only after the required ones are counted.
// RULE11 - While a controller holds the channel, echo is inverted D.
// RULE12 - Controller sends only while go, frees bus-accessed when frame ends.
// RULE13 - Bus-accessed back at 1: plain echo, stop/go 1, ready.
// RULE14 - Active terminal D data is passed upstream in channel 0.
// RULE15 - Permit bit 0: inverted echo, stop/go is complement of permit.
// RULE16 - Stop/go always written in channel 2 regardless of strapped channel.
// RULE17 - Several requesting controllers resolve contention on the arbitration bus.
// RULE18 - Bus-accessed bit is bit 5 of channel 2 last octet upstream.
// RULE19 - Stop/go is bit 5 of channel 2 last octet downstream.
// RULE20 - Address compared bitwise; lowest wins, loser withdraws at once.
// RULE21 - Ones counter restarts from zero on any upstream zero bit.
`timescale 1ns/10ps
module ntarb_arbiter (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  // Configuration
  input  wire ntarb_pkg::ntarb_cfg_t      cfg,
  // Incoming frames
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire ntarb_pkg::ntarb_frame_in_t in_frame,
  // Outgoing frames
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output ntarb_pkg::ntarb_frame_out_t     out_frame,
  // Status
  output ntarb_pkg::ntarb_state_t         arb_state,
  output logic                            arb_active,
  output logic                            lts_machine,
  output logic                            lower_level
);
  import ntarb_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    ntarb_state_t fsm;
    logic         success;   // last local transmission was not aborted
    logic         aborted;   // abort seen during current grant
    logic         active;
    logic         lts;
  } ntarb_arb_st_t;

  ntarb_arb_st_t    st;
  ntarb_arb_st_t    next_st;
  ntarb_frame_out_t word;
  logic             fire;
  logic             buf_ready;
  logic             arb_en;
  logic             bac;
  logic [CNT_W-1:0] ones;
  logic [CNT_W-1:0] need;

  initial
  begin
    if (TE_SLOTS != 12) $error("ntarb_arbiter: TE frame must hold 12 slots");
  end

  assign fire     = in_valid && buf_ready;
  assign in_ready = buf_ready;
  assign bac      = in_frame.up_ch2_oct[BAC_POS];                  // RULE18

  assign arb_en = (cfg.mode[2:1] == MODE_INT_NT)                   // RULE1
               && (cfg.dim == DIM_SG_EVAL)                         // RULE2
               && cfg.te_frame && cfg.arb_bus_en;                  // RULE3

  assign need = (cfg.dchan_priority_select ? PRIO_HIGH_CNT : PRIO_LOW_CNT)         // RULE5
              + (st.success ? LOWER_LEVEL : '0);                   // RULE6

  // --------------------------------------------------------------------------
  // Consecutive ones on the upstream D-channel
  // --------------------------------------------------------------------------
  ntarb_ones_cnt #(
    .W         (CNT_W)
  ) u_ones (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .bit_valid (fire),
    .bits      (in_frame.up_d),
    .count     (ones)
  );

  // --------------------------------------------------------------------------
  // Arbitration state machine
  // --------------------------------------------------------------------------
  always_comb
  begin
    next_st        = st;
    next_st.active = arb_en;
    next_st.lts    = cfg.mode[0];                                  // RULE1
    if (fire)
    begin
      if (!arb_en)
        next_st.fsm = NTARB_OFF;
      else if (!in_frame.line_permit)
        next_st.fsm = NTARB_BLOCK;                                 // RULE7
      else
      begin
        case (st.fsm)
          NTARB_GRANT:
          begin
            if (in_frame.tx_abort)
              next_st.aborted = 1'b1;
            if (bac)
            begin
              next_st.fsm     = NTARB_READY;                       // RULE13
              next_st.success = !(st.aborted || in_frame.tx_abort);// RULE6
              next_st.aborted = 1'b0;
            end
          end
          NTARB_READY:
          begin
            if (!bac && ones >= need)
            begin
              next_st.fsm     = NTARB_GRANT;                       // RULE4
              next_st.aborted = in_frame.tx_abort;
            end
          end
          default:
            next_st.fsm = NTARB_READY;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      st <= '{fsm: NTARB_OFF, default: '0};
    else
      st <= next_st;
  end

  // --------------------------------------------------------------------------
  // Outgoing frame word
  // --------------------------------------------------------------------------
  always_comb
  begin
    word            = '0;
    word.sg_chan    = SG_CHANNEL;                                  // RULE16
    word.dn_ch2_oct = OCT_IDLE;                                    // RULE19
    word.up_d       = D_IDLE;
    word.echo       = in_frame.up_d;                               // RULE13
    if (next_st.fsm == NTARB_GRANT)
    begin
      word.dn_ch2_oct[SG_POS] = 1'b0;                              // RULE10
      word.echo               = ~in_frame.up_d;                    // RULE11
    end
    else if (next_st.fsm == NTARB_BLOCK)
    begin
      word.dn_ch2_oct[SG_POS] = !in_frame.line_permit;             // RULE15
      word.echo               = ~in_frame.up_d;                    // RULE15
    end
    else
    begin
      word.dn_ch2_oct[SG_POS] = 1'b1;                              // RULE8
      if (in_frame.s_active)
        word.up_d = in_frame.s_d;                                  // RULE14
    end
  end

  // --------------------------------------------------------------------------
  // Output buffer
  // --------------------------------------------------------------------------
  ntarb_skid_buf #(
    .WIDTH     ($bits(ntarb_frame_out_t))
  ) u_buf (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (in_valid),
    .in_ready  (buf_ready),
    .in_data   (word),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_frame)
  );

  assign arb_state   = st.fsm;
  assign arb_active  = st.active;
  assign lts_machine = st.lts;
  assign lower_level = st.success;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_grant_on_count: assert property (
    fire && arb_en && in_frame.line_permit && st.fsm == NTARB_READY
    && !bac && ones >= need |=> arb_state == NTARB_GRANT)  // RULE4
    else $error("grant not taken on threshold");

  a_no_early_go: assert property (
    fire && st.fsm == NTARB_READY && ones < need
    |=> arb_state != NTARB_GRANT)  // RULE10
    else $error("go given before ones counted");

  a_release_ready: assert property (
    fire && arb_en && in_frame.line_permit && st.fsm == NTARB_GRANT && bac
    |=> arb_state == NTARB_READY)  // RULE13
    else $error("bus-accessed release not honoured");

  a_permit_block: assert property (
    fire && arb_en && !in_frame.line_permit
    |-> word.echo == ~in_frame.up_d && word.dn_ch2_oct[SG_POS]
    ##1 arb_state == NTARB_BLOCK)  // RULE7
    else $error("permit low did not block");

  a_mode_gate: assert property (
    fire && !arb_en |=> arb_state == NTARB_OFF)  // RULE2
    else $error("arbiter active outside its mode");

  a_need_value: assert property (
    need == (cfg.dchan_priority_select ? 4'hA : 4'h8) + {3'h0, st.success})  // RULE6
    else $error("threshold wrong for class and level");

  a_grant_echo: assert property (
    fire && next_st.fsm == NTARB_GRANT
    |-> word.echo == ~in_frame.up_d && !word.dn_ch2_oct[SG_POS])  // RULE11
    else $error("grant without inverted echo and go");

  a_ready_pass: assert property (
    fire && next_st.fsm == NTARB_READY && in_frame.s_active
    |-> word.up_d == in_frame.s_d && word.dn_ch2_oct[SG_POS])  // RULE14
    else $error("terminal data not passed upstream");

  a_sg_channel: assert property (
    out_valid |-> out_frame.sg_chan == 3'h2)  // RULE16
    else $error("stop/go not in channel 2");

  a_stall_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_frame))
    else $error("buffered word lost on stall");

  c_local_grant: cover property (
    arb_state == NTARB_READY ##1 arb_state == NTARB_GRANT
    ##[1:50] arb_state == NTARB_READY);
  c_block: cover property (arb_state == NTARB_BLOCK);
  c_full_stall: cover property (!in_ready ##1 in_ready);
  c_lower_level: cover property ($rose(lower_level));

endmodule // ntarb_arbiter

// ===== tb/ntarb_far_model.sv
// Far-side model: local HDLC controllers and S-bus terminals.
// Assumes a word is taken on a rising edge with valid and ready high.
`timescale 1ns/10ps
module ntarb_far_model (
  // Clock
  input  wire logic                  clk_sys,
  // Frame stream towards the arbiter
  output logic                       in_valid,
  input  wire logic                  in_ready,
  output ntarb_pkg::ntarb_frame_in_t in_frame
);
  import ntarb_pkg::*;

  localparam time DLY = 1ns;

  initial
  begin
    in_valid = 1'b0;
    in_frame = '1;
  end

  // Idle word: ones on D, bus free, line permitted
  function automatic ntarb_frame_in_t idle_f();
    ntarb_frame_in_t f;
    f             = '0;
    f.up_d        = D_IDLE;
    f.up_ch2_oct  = OCT_IDLE;
    f.line_permit = 1'b1;
    return f;
  endfunction

  // Wired-AND address contest; a loser stops sending at its lost bit
  function automatic logic [2:0] tic_win(input logic [2:0] a, b);
    logic [2:0] line;
    logic       a_in;
    logic       b_in;
    a_in = 1'b1;
    b_in = 1'b1;
    for (int i = 2; i >= 0; i--)
    begin
      line[i] = (a[i] | ~a_in) & (b[i] | ~b_in);
      a_in    = a_in & (line[i] | ~a[i]);
      b_in    = b_in & (line[i] | ~b[i]);
    end
    return line;
  endfunction

  // Request word, sent only after the bus was seen free
  function automatic ntarb_frame_in_t req(input logic [2:0] a, b);
    ntarb_frame_in_t f;
    f                     = idle_f();
    f.up_ch2_oct[4:2]     = tic_win(a, b);
    f.up_ch2_oct[BAC_POS] = 1'b0;
    return f;
  endfunction

  // Offers words back to back; released lines show the inverse
  task automatic put(input ntarb_frame_in_t fq[$]);
    @(posedge clk_sys);
    #DLY;
    foreach (fq[i])
    begin
      in_valid = 1'b1;
      in_frame = fq[i];
      do @(posedge clk_sys); while (!in_ready);
      #DLY;
    end
    in_valid = 1'b0;
    in_frame = ~in_frame;
  endtask
endmodule // ntarb_far_model

// ===== tb/ntarb_arbiter_test.sv
// Self-checking bench of the intelligent NT D-channel arbiter.
// Assumes ntarb_far_model drives the input stream.
`timescale 1ns/10ps
module ntarb_arbiter_test;
  import ntarb_pkg::*;

  localparam time        DLY       = 1ns;
  localparam int         LIMIT     = 8000;
  localparam logic [8:0] MODES [8] = '{9'h1CB, 9'h0CB, 9'h14B, 9'h1C3,
                                       9'h1DB, 9'h1C9, 9'h1CA, 9'h18B};

  logic             clk_sys;
  logic             reset;
  logic             in_valid;
  logic             in_ready;
  logic             out_valid;
  logic             out_ready;
  logic             arb_active;
  logic             lts_machine;
  logic             lower_level;
  ntarb_cfg_t       cfg;
  ntarb_frame_in_t  in_frame;
  ntarb_frame_in_t  f;
  ntarb_frame_in_t  fq[$];
  ntarb_frame_out_t out_frame;
  ntarb_frame_out_t o;
  ntarb_frame_out_t got[$];
  ntarb_state_t     arb_state;
  int               miscompares = 0;
  int               check_count = 0;
  int               cycles      = 0;

  ntarb_arbiter dut_u (.clk_sys(clk_sys), .reset(reset), .cfg(cfg),
    .in_valid(in_valid), .in_ready(in_ready), .in_frame(in_frame),
    .out_valid(out_valid), .out_ready(out_ready), .out_frame(out_frame),
    .arb_state(arb_state), .arb_active(arb_active),
    .lts_machine(lts_machine), .lower_level(lower_level));

  ntarb_far_model far_u (.clk_sys(clk_sys), .in_valid(in_valid),
    .in_ready(in_ready), .in_frame(in_frame));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Words seen here are taken at the next rising edge
  always @(negedge clk_sys)
    if (out_valid && out_ready)
      got.push_back(out_frame);

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      wrap_up();
    end
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick();
    @(posedge clk_sys);
    #DLY;
  endtask

  // One frame in, its answer popped into o
  task automatic step(input ntarb_frame_in_t w);
    fq = {w};
    far_u.put(fq);
    while (got.size() == 0)
      @(negedge clk_sys) #DLY;
    o = got.pop_front();
    tick();
  endtask

  // Ones run of 2*k after a pair pre, then a request
  task automatic attempt(input logic [1:0] pre, input int k,
                         input logic grant, abort);
    ntarb_frame_in_t g;
    g      = far_u.idle_f();
    g.up_d = pre;
    step(g);
    g.up_d = D_IDLE;
    repeat (k) step(g);
    step(far_u.req(3'h5, 3'h3));
    check("req_sg", o.dn_ch2_oct[SG_POS], !grant);
    check("req_state", arb_state, grant ? NTARB_GRANT : NTARB_READY);
    check("req_echo", o.echo, grant ? 2'h0 : 2'h3);
    check("sg_chan", o.sg_chan, SG_CHANNEL);
    if (grant)
    begin
      g          = far_u.req(3'h5, 3'h3);
      g.up_d     = 2'h1;
      g.tx_abort = abort;
      step(g);
      check("data_echo", o.echo, 2'h2);
      check("data_sg", o.dn_ch2_oct[SG_POS], 1'b0);
      step(far_u.idle_f());
      check("end_oct", o.dn_ch2_oct, OCT_IDLE);
      check("end_echo", o.echo, 2'h3);
      check("end_state", arb_state, NTARB_READY);
      check("lower", lower_level, !abort);
    end
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    reset     = 1'b1;
    out_ready = 1'b1;
    cfg       = MODES[0];
    repeat (20) @(posedge clk_sys);
    #DLY;
    reset = 1'b0;
    check("rst_ready", in_ready, 1'b1);
    check("rst_valid", out_valid, 1'b0);
    attempt(2'h1, 3, 1'b0, 1'b0);
    attempt(2'h2, 4, 1'b1, 1'b1);
    attempt(2'h1, 4, 1'b1, 1'b0);
    attempt(2'h2, 4, 1'b0, 1'b0);
    attempt(2'h1, 4, 1'b1, 1'b1);
    cfg.dchan_priority_select = 1'b1;
    attempt(2'h1, 4, 1'b0, 1'b0);
    attempt(2'h2, 5, 1'b1, 1'b0);
    attempt(2'h2, 5, 1'b0, 1'b0);
    attempt(2'h1, 5, 1'b1, 1'b1);
    $display("test thresholds done");

    repeat (6) step(far_u.idle_f());
    f             = far_u.idle_f();
    f.line_permit = 1'b0;
    step(f);
    check("blk_state", arb_state, NTARB_BLOCK);
    check("blk_sg", o.dn_ch2_oct[SG_POS], !f.line_permit);
    check("blk_echo", o.echo, 2'h0);
    f             = far_u.req(3'h1, 3'h6);
    f.line_permit = 1'b0;
    step(f);
    check("blk_req", arb_state, NTARB_BLOCK);
    check("blk_sg2", o.dn_ch2_oct[SG_POS], 1'b1);
    step(far_u.idle_f());
    check("unblock", arb_state, NTARB_READY);
    $display("test permit done");

    f          = far_u.idle_f();
    f.s_active = 1'b1;
    f.s_d      = 2'h2;
    step(f);
    check("te_up", o.up_d, 2'h2);
    check("te_oct", o.dn_ch2_oct, OCT_IDLE);
    $display("test terminal done");

    out_ready = 1'b0;
    fq        = {};
    for (int i = 0; i < 4; i++)
    begin
      f.s_d = i[1:0];
      fq.push_back(f);
    end
    fork
      far_u.put(fq);
      begin
        repeat (12) tick();
        check("full", in_ready, 1'b0);
        check("stalled", got.size(), 16'h0);
        out_ready = 1'b1;
      end
    join
    repeat (6) tick();
    check("drained", got.size(), 16'h4);
    for (int i = 0; i < 4; i++)
    begin
      o = got.pop_front();
      check("order", o.up_d, i[1:0]);
    end
    check("empty", out_valid, 1'b0);
    $display("test buffer done");

    for (int i = 0; i < 8; i++)
    begin
      cfg = MODES[i];
      repeat (3) tick();
      check("active", arb_active, i % 7 == 0);
      if (i % 7 == 0)
        check("lts", lts_machine, cfg.mode[0]);
      repeat (5) step(far_u.idle_f());
      step(far_u.req(3'h2, 3'h4));
      check("m_state", arb_state, i % 7 == 0 ? NTARB_GRANT : NTARB_OFF);
      check("m_sg", o.dn_ch2_oct[SG_POS], i % 7 != 0);
      step(far_u.idle_f());
    end
    $display("test modes done");
    wrap_up();
  end
endmodule // ntarb_arbiter_test
